// >>> hw/led_matrix_scan_control.sv
// Purpose: Register file and column scan engine of an LED dot matrix driver
// Assumes: Serial slave logic on ref_clk presents register requests as strobes
// Notes:   Analog bar levels arrive asynchronously and are synchronised here
//
// Overview of operation
// [R1] Column writes land in shadow storage only
// [R2] Any write to update copies shadow to active
// [R3] Intensity: gain bits 6:4, current bits 3:0
// [R4] Gain codes 0..6 step 3 dB, 7 is -6dB
// [R5] Current codes 40-75 mA, then 5-35 mA
// [R6] Equalizer register bit 6 enables bar mode
// [R7] Bar mode still uses the row current field
// [R8] Bar mode drives eight columns, rest stay off
// [R9] Power-up shape is eight by eight
// [R10] One column at a time, 32us on, 1us gap
// [R11] Each extra column adds 33us; nine drops top bit
// [R12] Shape 11 drives five rows, eleven columns
// [R13] Eight by eight uses column registers 1 to 8
// [R14] Audio modulation bit makes intensity follow audio; the code holds audio_mod_enable low while bar mode is on
// [R15] Reset gives defaults and blank display
// [R16] Shutdown turns off rows and columns
// [R17] Shutdown keeps all registers, resumes afterwards
// [R18] Host may blink display through shutdown
// [R19] Config: shutdown bit 7, audio bit 2, shape 1:0
// [R20] Pattern bit one lights LED; unused rows ignored
// [R21] Columns scan ascending; current code 1111 reserved
`timescale 1ns/10ps
`default_nettype none

module led_matrix_scan_control #(
  parameter int ON_CYCLES  = led_scan_pkg::ON_CYC,
  parameter int GAP_CYCLES = led_scan_pkg::GAP_CYC
) (
  input  wire logic                                   ref_clk,
  input  wire logic                                   reset,
  input  wire logic                                   clk_en,
  input  wire led_scan_pkg::reg_req_t                 reg_req,
  output logic       [7:0]                            reg_rdata,
  input  wire logic  [led_scan_pkg::EQ_COLS-1:0][7:0] eq_bar_level,
  output logic       [led_scan_pkg::NUM_COLS-1:0]     col_drive,
  output logic       [led_scan_pkg::ROWS-1:0]         row_drive,
  output logic                                        current_enable,
  output logic       [3:0]                            row_current_code,
  output logic       [6:0]                            row_current_ma,
  output logic       [2:0]                            audio_gain_code,
  output logic signed [5:0]                           audio_gain_db,
  output logic                                        audio_mod_enable,
  output logic                                        eq_mode_enable
);

  localparam int CNT_W = led_scan_pkg::CNT_W;

  led_scan_pkg::scan_regs_t st;
  led_scan_pkg::scan_regs_t next_st;

  logic [1:0] array_shape_select;
  logic       soft_shutdown;
  logic [3:0] scan_cols;
  logic [7:0] row_mask;

  function automatic logic is_col_addr(input logic [7:0] addr);
    return addr >= led_scan_pkg::COL_FIRST_ADDR && addr <= led_scan_pkg::COL_LAST_ADDR;
  endfunction

  // Shape 00..11 keeps 8..5 rows, so the mask simply shifts down
  function automatic logic [7:0] rows_for_shape(input logic [1:0] shape);
    return 8'hff >> shape; // R12 R20
  endfunction

  function automatic logic signed [5:0] gain_to_db(input logic [2:0] code);
    if (code == 3'h7) begin
      return -6'sd6; // R4
    end
    return 6'($unsigned(code) * 3); // R4
  endfunction

  function automatic logic [6:0] current_to_ma(input logic [3:0] code);
    if (code == led_scan_pkg::CURRENT_RESERVED) begin
      return 7'h00; // R21
    end
    if (code[3]) begin
      return 7'(({4'h0, code[2:0]} + 7'h01) * 5); // R5
    end
    return 7'(7'd40 + {4'h0, code[2:0]} * 5); // R5
  endfunction

  assign array_shape_select = st.config_reg[led_scan_pkg::SHAPE_LSB +: 2]; // R19
  assign soft_shutdown      = st.config_reg[led_scan_pkg::SHUTDOWN_BIT]; // R19
  assign eq_mode_enable     = st.equalizer_control[led_scan_pkg::EQ_ENABLE_BIT]; // R6
  assign scan_cols          = 4'(8 + array_shape_select); // R11
  assign row_mask           = rows_for_shape(array_shape_select);

  always_comb begin
    logic [3:0] col;
    logic       last_col;
    logic [7:0] pattern;
    col      = 4'h0;
    last_col = 1'b0;
    pattern  = 8'h00;
    next_st  = st;

    // Register writes
    if (reg_req.wr) begin
      if (reg_req.addr == led_scan_pkg::CONFIG_ADDR) begin
        next_st.config_reg = reg_req.wdata & led_scan_pkg::CONFIG_MASK; // R19
      end
      if (is_col_addr(reg_req.addr)) begin
        col = 4'(reg_req.addr - led_scan_pkg::COL_FIRST_ADDR);
        next_st.shadow[col] = reg_req.wdata; // R1
      end
      if (reg_req.addr == led_scan_pkg::UPDATE_ADDR) begin
        next_st.active = st.shadow; // R2
      end
      if (reg_req.addr == led_scan_pkg::INTENSITY_ADDR) begin
        next_st.intensity_control = reg_req.wdata & led_scan_pkg::INTENSITY_MASK; // R3
      end
      if (reg_req.addr == led_scan_pkg::EQ_ADDR) begin
        next_st.equalizer_control = reg_req.wdata & led_scan_pkg::EQ_MASK; // R6
      end
    end

    // Reads show the live pattern, not the pending shadow
    next_st.rdata = 8'h00;
    if (reg_req.rd) begin
      if (reg_req.addr == led_scan_pkg::CONFIG_ADDR) begin
        next_st.rdata = st.config_reg;
      end else if (is_col_addr(reg_req.addr)) begin
        next_st.rdata = st.active[4'(reg_req.addr - led_scan_pkg::COL_FIRST_ADDR)];
      end else if (reg_req.addr == led_scan_pkg::INTENSITY_ADDR) begin
        next_st.rdata = st.intensity_control;
      end else if (reg_req.addr == led_scan_pkg::EQ_ADDR) begin
        next_st.rdata = st.equalizer_control;
      end
    end

    // Bar levels come from the analog side, another timing domain
    next_st.eq_meta  = eq_bar_level;
    next_st.eq_level = st.eq_meta;

    // Scan engine: gap, then column on, ascending column order
    last_col = st.col_idx >= 4'(scan_cols - 4'h1);
    case (st.state)
      led_scan_pkg::SCAN_IDLE: begin
        next_st.count   = '0;
        next_st.col_idx = 4'h0; // R21
        if (!soft_shutdown) begin
          next_st.state = led_scan_pkg::SCAN_GAP;
        end
      end
      led_scan_pkg::SCAN_GAP: begin
        if (st.count >= CNT_W'(GAP_CYCLES - 1)) begin
          next_st.count = '0;
          next_st.state = led_scan_pkg::SCAN_ON; // R10
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end
      led_scan_pkg::SCAN_ON: begin
        if (st.count >= CNT_W'(ON_CYCLES - 1)) begin
          next_st.count   = '0;
          next_st.state   = led_scan_pkg::SCAN_GAP; // R10
          next_st.col_idx = last_col ? 4'h0 : st.col_idx + 4'h1; // R11 R21
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end
      default: begin
        next_st.state = led_scan_pkg::SCAN_IDLE;
      end
    endcase
    // A shape shrink mid-frame must not leave the index past the end
    if (st.col_idx >= scan_cols) begin
      next_st.col_idx = 4'h0;
    end
    // Shutdown parks the scanner but leaves every register alone
    if (soft_shutdown) begin
      next_st.state = led_scan_pkg::SCAN_IDLE; // R16 R17
      next_st.count = '0;
    end

    // Drive outputs from the current scan position
    next_st.col_drive = '0;
    next_st.row_drive = '0;
    if (st.state == led_scan_pkg::SCAN_ON && !soft_shutdown && st.col_idx < scan_cols) begin
      if (eq_mode_enable) begin
        if (st.col_idx < 4'(led_scan_pkg::EQ_COLS)) begin // R8
          pattern = st.eq_level[st.col_idx[2:0]];
          next_st.col_drive[st.col_idx] = 1'b1;
        end
      end else begin
        pattern = st.active[st.col_idx]; // R13
        next_st.col_drive[st.col_idx] = 1'b1; // R10
      end
      next_st.row_drive = pattern & row_mask; // R12 R20
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st                   <= '0; // R15
      st.config_reg        <= led_scan_pkg::CONFIG_RESET; // R9
      st.intensity_control <= led_scan_pkg::INTENSITY_RESET;
      st.equalizer_control <= led_scan_pkg::EQ_RESET;
      st.shadow            <= {led_scan_pkg::NUM_COLS{led_scan_pkg::COL_RESET}};
      st.active            <= {led_scan_pkg::NUM_COLS{led_scan_pkg::COL_RESET}};
      st.state             <= led_scan_pkg::SCAN_IDLE;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign reg_rdata        = st.rdata;
  assign col_drive        = st.col_drive;
  assign row_drive        = st.row_drive;
  assign current_enable   = !soft_shutdown; // R16
  assign row_current_code = st.intensity_control[led_scan_pkg::CURRENT_LSB +: 4]; // R3 R7
  assign row_current_ma   = current_to_ma(row_current_code); // R5
  assign audio_gain_code  = st.intensity_control[led_scan_pkg::GAIN_LSB +: 3]; // R3
  assign audio_gain_db    = gain_to_db(audio_gain_code); // R4
  assign audio_mod_enable = st.config_reg[led_scan_pkg::AUDIO_MOD_BIT] && !eq_mode_enable; // R14

  // Checks on the engine's own behaviour

  shadow_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // R1
    (clk_en && reg_req.wr && is_col_addr(reg_req.addr)) |=> $stable(st.active))
    else $error("column write reached active pattern without update");

  update_copy_a: assert property (@(posedge ref_clk) disable iff (reset) // R2
    (clk_en && reg_req.wr && reg_req.addr == led_scan_pkg::UPDATE_ADDR)
      |=> st.active == $past(st.shadow))
    else $error("update did not copy shadow to active");

  row_mask_a: assert property (@(posedge ref_clk) disable iff (reset) // R12
    clk_en |=> (row_drive & ~$past(row_mask)) == 8'h00)
    else $error("unused row driven for this shape");

  eq_columns_a: assert property (@(posedge ref_clk) disable iff (reset) // R8
    (clk_en && eq_mode_enable) |=> col_drive[10:8] == 3'h0)
    else $error("column beyond eight driven in bar mode");

  shutdown_blank_a: assert property (@(posedge ref_clk) disable iff (reset) // R16
    (clk_en && soft_shutdown) |-> (!current_enable ##1 (col_drive == '0 && row_drive == '0)))
    else $error("array not blank in shutdown");

  one_column_a: assert property (@(posedge ref_clk) disable iff (reset) // R10
    $onehot0(col_drive))
    else $error("more than one column active");

  gap_end_a: assert property (@(posedge ref_clk) disable iff (reset) // R10
    (clk_en && !soft_shutdown && st.state == led_scan_pkg::SCAN_GAP
      && st.count == CNT_W'(GAP_CYCLES - 1))
      |=> (st.state == led_scan_pkg::SCAN_ON && st.count == '0))
    else $error("gap length wrong");

  on_end_a: assert property (@(posedge ref_clk) disable iff (reset) // R11
    (clk_en && !soft_shutdown && st.state == led_scan_pkg::SCAN_ON
      && st.count == CNT_W'(ON_CYCLES - 1) && st.col_idx < scan_cols)
      |=> (st.state == led_scan_pkg::SCAN_GAP && st.col_idx ==
           ($past(st.col_idx) == $past(scan_cols) - 4'h1 ? 4'h0 : $past(st.col_idx) + 4'h1)))
    else $error("column period or ascending order wrong");

  regs_kept_a: assert property (@(posedge ref_clk) disable iff (reset) // R17
    (clk_en && soft_shutdown && !reg_req.wr)
      |=> ($stable(st.active) && $stable(st.intensity_control) && $stable(st.equalizer_control)))
    else $error("register changed in shutdown without a write");

  reserved_current_a: assert property (@(posedge ref_clk) disable iff (reset) // R21
    (row_current_code == led_scan_pkg::CURRENT_RESERVED) |-> row_current_ma == 7'h00)
    else $error("reserved current code gives nonzero current");

endmodule

`default_nettype wire

// >>> shared/led_scan_pkg.sv
// Purpose: Shared constants and types for the LED matrix scan controller
// Assumes: Register writes arrive as single-cycle strobes on ref_clk
// Notes:   Times are in ns; cycle counts derive from the 125 MHz clock
package led_scan_pkg;

  localparam int NUM_COLS      = 11;
  localparam int EQ_COLS       = 8;
  localparam int ROWS          = 8;

  // Register offsets
  localparam logic [7:0] CONFIG_ADDR    = 8'h00;
  localparam logic [7:0] COL_FIRST_ADDR = 8'h01;
  localparam logic [7:0] COL_LAST_ADDR  = 8'h0b;
  localparam logic [7:0] UPDATE_ADDR    = 8'h0c;
  localparam logic [7:0] INTENSITY_ADDR = 8'h0d;
  localparam logic [7:0] EQ_ADDR        = 8'h0f;

  // Field positions
  localparam int SHUTDOWN_BIT  = 7;
  localparam int AUDIO_MOD_BIT = 2;
  localparam int SHAPE_LSB     = 0;
  localparam int GAIN_LSB      = 4;
  localparam int CURRENT_LSB   = 0;
  localparam int EQ_ENABLE_BIT = 6;

  // Reset values and writable bits
  localparam logic [7:0] CONFIG_RESET    = 8'h00;
  localparam logic [7:0] COL_RESET       = 8'h00;
  localparam logic [7:0] INTENSITY_RESET = 8'h00;
  localparam logic [7:0] EQ_RESET        = 8'h00;
  localparam logic [7:0] CONFIG_MASK     = 8'h87;
  localparam logic [7:0] INTENSITY_MASK  = 8'h7f;
  localparam logic [7:0] EQ_MASK         = 8'h40;
  localparam logic [3:0] CURRENT_RESERVED = 4'hf;

  // Scan timing
  localparam int CLK_MHZ   = 125;
  localparam int COL_ON_NS = 32000;
  localparam int GAP_NS    = 1000;
  localparam int ON_CYC    = (COL_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC   = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W     = 12;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_GAP  = 2'b01,
    SCAN_ON   = 2'b10
  } scan_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0]                 config_reg;
    logic [7:0]                 intensity_control;
    logic [7:0]                 equalizer_control;
    logic [NUM_COLS-1:0][7:0]   shadow;
    logic [NUM_COLS-1:0][7:0]   active;
    logic [EQ_COLS-1:0][7:0]    eq_meta;
    logic [EQ_COLS-1:0][7:0]    eq_level;
    scan_state_t                state;
    logic [CNT_W-1:0]           count;
    logic [3:0]                 col_idx;
    logic [NUM_COLS-1:0]        col_drive;
    logic [ROWS-1:0]            row_drive;
    logic [7:0]                 rdata;
  } scan_regs_t;

endpackage

// >>> verification/host_model.sv
// Purpose: Host controller model issuing register strobes to the scan block
// Assumes: Each request launches 1 ns after a rising edge and is taken at the next edge
// Notes:   Write data lines show the inverted value between accesses, never a stale copy
`timescale 1ns/10ps
`default_nettype none

module host_model (
  input  wire logic                  ref_clk,
  output var  led_scan_pkg::reg_req_t reg_req,
  input  wire logic [7:0]            reg_rdata
);
  initial reg_req = '0;

  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_req.wr    = w;
    reg_req.rd    = !w;
    reg_req.addr  = a;
    reg_req.wdata = d;
    @(posedge ref_clk);
    #1;
    reg_req.wr    = 1'b0;
    reg_req.rd    = 1'b0;
    reg_req.wdata = ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, a, d);
  endtask

  // Read data stands for one cycle only, so it is taken right after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(1'b0, a, 8'h00);
    d = reg_rdata;
  endtask

  // Any byte works; a non-zero one shows the value is ignored
  task automatic commit();
    wr(led_scan_pkg::UPDATE_ADDR, 8'h5a);
  endtask

  // Blanking and restoring through shutdown, as used for flashing
  task automatic shutdown(input logic on, input logic [7:0] cfg);
    wr(led_scan_pkg::CONFIG_ADDR, on ? (cfg | 8'h80) : (cfg & 8'h7f));
  endtask
endmodule

`default_nettype wire

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the LED matrix scan controller
// Assumes: Short scan timing (8 on, 2 gap cycles) set through parameters
// Notes:   Intensity decode runs from a table; scan and shutdown cases follow by hand
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam int ON  = 8;
  localparam int GAP = 2;
  typedef struct packed {
    logic [7:0] wdata;
    logic [6:0] ma;
    logic [5:0] db;
  } int_row_t;

  logic                   ref_clk;
  logic                   reset;
  logic                   clk_en;
  led_scan_pkg::reg_req_t reg_req;
  logic [7:0]             reg_rdata;
  logic [7:0][7:0]        eq_bar_level;
  logic [10:0]            col_drive;
  logic [10:0]            held;
  logic [7:0]             row_drive;
  logic                   current_enable;
  logic [3:0]             row_current_code;
  logic [6:0]             row_current_ma;
  logic [2:0]             audio_gain_code;
  logic signed [5:0]      audio_gain_db;
  logic                   audio_mod_enable;
  logic                   eq_mode_enable;
  logic [10:0][7:0]       pat;
  logic [7:0]             rv;
  int                     n_errors;
  int                     samples_checked;
  int_row_t rows [8] = '{'{8'h00, 7'h28, 6'h00}, '{8'h17, 7'h4b, 6'h03}, '{8'h28, 7'h05, 6'h06},
                         '{8'h3e, 7'h23, 6'h09}, '{8'h41, 7'h2d, 6'h0c}, '{8'h59, 7'h0a, 6'h0f},
                         '{8'h6f, 7'h00, 6'h12}, '{8'hf0, 7'h28, 6'h3a}};

  led_matrix_scan_control #(.ON_CYCLES(ON), .GAP_CYCLES(GAP)) led_matrix_scan_control_i (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .eq_bar_level(eq_bar_level), .col_drive(col_drive), .row_drive(row_drive),
    .current_enable(current_enable), .row_current_code(row_current_code),
    .row_current_ma(row_current_ma), .audio_gain_code(audio_gain_code), .audio_gain_db(audio_gain_db),
    .audio_mod_enable(audio_mod_enable), .eq_mode_enable(eq_mode_enable));

  host_model host_model_i (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  always #4 ref_clk = ~ref_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Follows one frame from column 0; gap after the last column is left out when slots are blanked
  task automatic scan(input int n, input logic [7:0] m, input logic [10:0][7:0] exp_r, input logic wrap);
    int c;
    int k;
    k = 0;
    // Start on a fresh column 0, not partway through one already lit
    while (col_drive === 11'h001 && k < 400) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    while (col_drive !== 11'h001 && k < 400) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    for (c = 0; c < n; c++) begin
      chk(16'(col_drive), 16'(11'h001 << c));
      chk(16'(row_drive), 16'(exp_r[c] & m));
      k = 0;
      while (col_drive === 11'(11'h001 << c) && k < 400) begin
        @(posedge ref_clk);
        #1;
        k++;
      end
      chk(16'(k), 16'(ON));
      k = 0;
      while (col_drive === 11'h000 && k < 400 && (wrap || c < n - 1)) begin
        @(posedge ref_clk);
        #1;
        k++;
      end
      if (wrap || c < n - 1)
        chk(16'(k), 16'(GAP));
    end
    if (wrap)
      chk(16'(col_drive), 16'h0001);
  endtask

  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end

  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    for (int i = 0; i < 8; i++)
      eq_bar_level[i] = 8'hff >> (7 - i);
    for (int i = 0; i < 11; i++)
      pat[i] = 8'(8'h81 + 8'h13 * i);
    repeat (16) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    chk(16'(col_drive), 16'h0000);
    chk(16'(current_enable), 16'h0001);
    host_model_i.rd(led_scan_pkg::CONFIG_ADDR, rv);
    chk(16'(rv), 16'h0000);
    host_model_i.rd(led_scan_pkg::EQ_ADDR, rv);
    chk(16'(rv), 16'h0000);
    host_model_i.rd(led_scan_pkg::UPDATE_ADDR, rv);
    chk(16'(rv), 16'h0000);
    foreach (rows[i]) begin
      host_model_i.wr(led_scan_pkg::INTENSITY_ADDR, rows[i].wdata);
      chk(16'(row_current_ma), 16'(rows[i].ma));
      chk(16'($unsigned(audio_gain_db)), 16'(rows[i].db));
      chk(16'(audio_gain_code), 16'(rows[i].wdata[6:4]));
      chk(16'(row_current_code), 16'(rows[i].wdata[3:0]));
      host_model_i.rd(led_scan_pkg::INTENSITY_ADDR, rv);
      chk(16'(rv), 16'(rows[i].wdata & 8'h7f));
    end
    for (int i = 0; i < 11; i++)
      host_model_i.wr(8'(led_scan_pkg::COL_FIRST_ADDR + i), pat[i]);
    host_model_i.rd(led_scan_pkg::COL_FIRST_ADDR, rv);
    chk(16'(rv), 16'h0000);
    host_model_i.commit();
    host_model_i.rd(led_scan_pkg::COL_FIRST_ADDR, rv);
    chk(16'(rv), 16'(pat[0]));
    scan(8, 8'hff, pat, 1'b1);
    host_model_i.wr(led_scan_pkg::CONFIG_ADDR, 8'h01);
    scan(9, 8'h7f, pat, 1'b1);
    host_model_i.wr(led_scan_pkg::CONFIG_ADDR, 8'h07);
    chk(16'(audio_mod_enable), 16'h0001);
    scan(11, 8'h1f, pat, 1'b1);
    host_model_i.wr(led_scan_pkg::EQ_ADDR, 8'hff);
    chk(16'(eq_mode_enable), 16'h0001);
    chk(16'(audio_mod_enable), 16'h0000);
    chk(16'(row_current_ma), 16'h0028);
    scan(8, 8'h1f, {24'h0, eq_bar_level}, 1'b0);
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      chk(16'(col_drive[10:8]), 16'h0000);
    end
    host_model_i.shutdown(1'b1, 8'h03);
    @(posedge ref_clk);
    #1;
    chk(16'(col_drive), 16'h0000);
    chk(16'({row_drive, current_enable}), 16'h0000);
    host_model_i.rd(led_scan_pkg::INTENSITY_ADDR, rv);
    chk(16'(rv), 16'h0070);
    host_model_i.rd(led_scan_pkg::EQ_ADDR, rv);
    chk(16'(rv), 16'h0040);
    host_model_i.wr(led_scan_pkg::EQ_ADDR, 8'h00);
    host_model_i.shutdown(1'b0, 8'h03);
    scan(11, 8'h1f, pat, 1'b1);
    // Enable low freezes the scan and refuses register writes
    clk_en = 1'b0;
    held = col_drive;
    host_model_i.wr(led_scan_pkg::INTENSITY_ADDR, 8'h05);
    repeat (20) @(posedge ref_clk);
    #1;
    chk(16'(col_drive), 16'(held));
    chk(16'(row_current_code), 16'h0000);
    clk_en = 1'b1;
    reset = 1'b1;
    @(posedge ref_clk);
    #1;
    reset = 1'b0;
    chk(16'(col_drive), 16'h0000);
    chk(16'(row_current_ma), 16'h0028);
    host_model_i.rd(led_scan_pkg::INTENSITY_ADDR, rv);
    chk(16'(rv), 16'h0000);
    host_model_i.rd(led_scan_pkg::COL_FIRST_ADDR, rv);
    chk(16'(rv), 16'h0000);
    give_verdict();
  end
endmodule

`default_nettype wire
